// ### dram_read_throttle.v
// Overview of operation
// R1 - global window in ms is four times bits 45:38
// R2 - global quadword threshold is bits 37:26 times two to the fifteenth
// R3 - count read quadwords per global window; throttle when count exceeds
// R4 - throttle lasts bits 25:20 global windows once triggered
// R5 - when duration expires stop throttling, resume global monitoring
// R6 - monitor window clocks is bits 19:13 with four zero bits appended
// R7 - while throttling, block host, PCI reads, AGP once window max reached
// R8 - per-window quadword maximum is bits 12:3
// R9 - after lock bit written one, read throttle register is read-only
// R10 - lock bit resets zero; once set both throttle registers read-only
// R11 - enable bit 3 gates system error on read or write throttling
// R12 - enable bit 2 zero gives one PCI clock pulse, one gives level
// R13 - enable bit 7 raises error when aperture-miss flag rises; resets one
// R14 - enable bit 6 sets invalid AGP read flag and raises error
// R15 - enable bit 5 sets invalid table entry flag and raises error
// R16 - enable bit 4 raises error on target abort
// R17 - enable bit 1 raises error on multi-bit ECC or parity error
// R18 - enable bit 0 raises error on single-bit ECC error
// R19 - system error also needs the PCI command error enable
// R20 - status bit 12 sets on read throttling, cleared by writing one
// R21 - error event only on zero-to-one transition of an enabled flag; target abort raises it each cycle its enabled input is high
// R22 - global and monitor counters clear at their window boundaries
`timescale 1ns/1ps
`include "throttle_consts.vh"
module dram_read_throttle #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter PCI_CYCLES = `PCI_CYCLES
)(
  input wire CLK_I,
  input wire NRST_I,
  input wire [7:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output wire [1:0] S_AXI_BRESP_O,
  output wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [7:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output wire [31:0] S_AXI_RDATA_O,
  output wire [1:0] S_AXI_RRESP_O,
  output wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire QW_READ_I,
  input wire WR_THROTTLE_EVT_I,
  input wire AGP_OUT_APERTURE_I,
  input wire AGP_INVALID_READ_I,
  input wire GATT_INVALID_I,
  input wire TARGET_ABORT_I,
  input wire MBIT_ERR_I,
  input wire SBIT_ERR_I,
  input wire [2:0] ERR_ROW_I,
  output wire BLOCK_HOST_PCI_RD_O,
  output wire BLOCK_AGP_O,
  output wire THROTTLE_ACTIVE_O,
  output wire SERR_O
);
  localparam ST_MON = 1'b0;
  localparam ST_THR = 1'b1;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] err_en_reg;
  reg [15:0] err_sts_reg;
  reg [15:0] err_sts_next;
  reg serr_en_reg;
  reg lock_reg;
  reg [63:0] rt_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg state_reg;
  reg state_next;
  reg [31:0] ms_pre_reg;
  reg [9:0] gw_ms_reg;
  reg [27:0] gqw_reg;
  reg [27:0] gqw_next;
  reg [5:0] dur_reg;
  reg [5:0] dur_next;
  reg [10:0] mon_cnt_reg;
  reg [10:0] mqw_reg;
  reg [10:0] mqw_next;
  reg block_reg;
  reg rd_thr_evt;
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (st[k])
          merge[k*8 +: 8] = wd[k*8 +: 8];
    end
  endfunction
  // ----------------------------------------
  // throttle fields
  // ----------------------------------------
  wire [7:0] gw_field;
  wire [11:0] gt_field;
  wire [5:0] rtt_field;
  wire [6:0] mw_field;
  wire [9:0] qm_field;
  wire [9:0] win_ms;
  wire [9:0] win_m1;
  wire [26:0] g_thresh;
  wire [10:0] mon_len;
  wire [10:0] mon_m1;
  assign gw_field = rt_reg[`GW_HI:`GW_LO];
  assign gt_field = rt_reg[`GT_HI:`GT_LO];
  assign rtt_field = rt_reg[`RTT_HI:`RTT_LO];
  assign mw_field = rt_reg[`MW_HI:`MW_LO];
  assign qm_field = rt_reg[`QM_HI:`QM_LO];
  assign win_ms = {gw_field, 2'b00}; // R1
  assign win_m1 = win_ms - 10'h001;
  assign g_thresh = {gt_field, 15'h0000}; // R2
  assign mon_len = {mw_field, 4'h0}; // R6
  assign mon_m1 = mon_len - 11'h001;
  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  wire aw_fire;
  wire w_fire;
  wire ar_fire;
  wire wr_go;
  wire wr_lock_ok;
  wire [31:0] rt_lo_new;
  wire [31:0] rt_hi_new;
  assign S_AXI_AWREADY_O = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_hold_reg && !bvalid_reg;
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_fire = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_lock_ok = !lock_reg; // R9 R10
  assign rt_lo_new = merge(rt_reg[31:0], wdata_reg, wstrb_reg);
  assign rt_hi_new = merge(rt_reg[63:32], wdata_reg, wstrb_reg);
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      err_en_reg <= `ERR_ENABLE_RST; // R13
      serr_en_reg <= 1'b0;
      lock_reg <= 1'b0; // R10
      rt_reg <= `RT_RST;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
      end
      if (w_fire)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
        wstrb_reg <= S_AXI_WSTRB_I;
      end
      if (bvalid_reg && S_AXI_BREADY_I)
        bvalid_reg <= 1'b0;
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `RESP_OKAY;
        case (awaddr_reg)
          `OFS_ERR_ENABLE:
            if (wstrb_reg[0])
              err_en_reg <= wdata_reg[7:0];
          `OFS_SERR_CTRL:
            if (wstrb_reg[0])
              serr_en_reg <= wdata_reg[0];
          `OFS_WT_HI:
            if (wr_lock_ok && wstrb_reg[3] && wdata_reg[`LOCK_BIT])
              lock_reg <= 1'b1; // R10
          `OFS_RT_LO:
            if (wr_lock_ok)
              rt_reg <= {rt_reg[63:32], rt_lo_new} & `RT_WMASK; // R9
          `OFS_RT_HI:
            if (wr_lock_ok)
              rt_reg <= {rt_hi_new, rt_reg[31:0]} & `RT_WMASK; // R9
          `OFS_ERR_STATUS, `OFS_THR_STATE, `OFS_WT_LO:
            bresp_reg <= `RESP_OKAY;
          default:
            bresp_reg <= `RESP_SLVERR;
        endcase
      end
    end
  end
  // read path
  reg [31:0] rd_mux;
  reg rd_hit;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR_I)
      `OFS_ERR_ENABLE: rd_mux = {24'h000000, err_en_reg};
      `OFS_ERR_STATUS: rd_mux = {16'h0000, err_sts_reg};
      `OFS_SERR_CTRL: rd_mux = {31'h00000000, serr_en_reg};
      `OFS_THR_STATE:
        rd_mux = {18'h00000, dur_reg, 6'h00, block_reg, state_reg};
      `OFS_WT_LO: rd_mux = 32'h00000000;
      `OFS_WT_HI: rd_mux = {lock_reg, 31'h00000000};
      `OFS_RT_LO: rd_mux = rt_reg[31:0];
      `OFS_RT_HI: rd_mux = rt_reg[63:32];
      default: rd_hit = 1'b0;
    endcase
  end
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_reg && S_AXI_RREADY_I)
      rvalid_reg <= 1'b0;
  end
  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;
  // ----------------------------------------
  // global window and throttle state
  // ----------------------------------------
  wire ms_tick;
  wire g_end;
  wire m_end;
  wire [31:0] ms_last;
  assign ms_last = MS_CYCLES - 1;
  assign ms_tick = (ms_pre_reg >= ms_last);
  assign g_end = ms_tick && (win_ms != 10'h000) &&
    (gw_ms_reg >= win_m1); // R1
  assign m_end = (mon_len == 11'h000) || (mon_cnt_reg >= mon_m1); // R6
  always @*
  begin
    state_next = state_reg;
    dur_next = dur_reg;
    rd_thr_evt = 1'b0;
    gqw_next = gqw_reg;
    if (QW_READ_I && gqw_reg != 28'hfffffff)
      gqw_next = gqw_reg + 28'h0000001; // R3
    if (g_end)
      gqw_next = 28'h0000000; // R22
    case (state_reg)
      ST_MON:
        if (gqw_reg > {1'b0, g_thresh} && win_ms != 10'h000)
        begin
          rd_thr_evt = 1'b1; // R3 R20
          gqw_next = 28'h0000000;
          dur_next = rtt_field; // R4
          if (rtt_field != 6'h00)
            state_next = ST_THR;
        end
      ST_THR:
      begin
        gqw_next = 28'h0000000;
        if (g_end)
        begin
          if (dur_reg <= 6'h01)
          begin
            dur_next = 6'h00;
            state_next = ST_MON; // R5
          end
          else
            dur_next = dur_reg - 6'h01; // R4
        end
      end
      default:
        state_next = ST_MON;
    endcase
  end
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_reg <= ST_MON;
      ms_pre_reg <= 32'h00000000;
      gw_ms_reg <= 10'h000;
      gqw_reg <= 28'h0000000;
      dur_reg <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      dur_reg <= dur_next;
      gqw_reg <= gqw_next;
      // window restarts when throttling is entered
      if (rd_thr_evt || ms_tick)
        ms_pre_reg <= 32'h00000000;
      else
        ms_pre_reg <= ms_pre_reg + 32'h00000001;
      if (rd_thr_evt || g_end)
        gw_ms_reg <= 10'h000; // R22
      else if (ms_tick)
        gw_ms_reg <= gw_ms_reg + 10'h001;
    end
  end
  // ----------------------------------------
  // monitor window and blocking
  // ----------------------------------------
  always @*
  begin
    mqw_next = mqw_reg;
    if (QW_READ_I && mqw_reg != 11'h7ff)
      mqw_next = mqw_reg + 11'h001; // R7
    if (m_end || state_reg != ST_THR)
      mqw_next = 11'h000; // R22
  end
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      mon_cnt_reg <= 11'h000;
      mqw_reg <= 11'h000;
      block_reg <= 1'b0;
    end
    else
    begin
      if (m_end || state_reg != ST_THR)
        mon_cnt_reg <= 11'h000; // R22
      else
        mon_cnt_reg <= mon_cnt_reg + 11'h001;
      mqw_reg <= mqw_next;
      block_reg <= (state_next == ST_THR) &&
        (mqw_next >= {1'b0, qm_field}); // R7 R8
    end
  end
  assign BLOCK_HOST_PCI_RD_O = block_reg; // R7
  assign BLOCK_AGP_O = block_reg; // R7
  assign THROTTLE_ACTIVE_O = state_reg;
  // ----------------------------------------
  // error status and system error events
  // ----------------------------------------
  reg [15:0] sts_set;
  reg [15:0] sts_mask;
  wire [15:0] sts_clr;
  wire [15:0] sts_rise;
  wire serr_evt;
  wire serr_hold;
  always @*
  begin
    sts_set = 16'h0000;
    sts_set[`ST_RTHR] = rd_thr_evt; // R20
    sts_set[`ST_WTHR] = WR_THROTTLE_EVT_I;
    sts_set[`ST_APER] = AGP_OUT_APERTURE_I;
    sts_set[`ST_AGPRD] = AGP_INVALID_READ_I && err_en_reg[`EN_AGPRD]; // R14
    sts_set[`ST_GATT] = GATT_INVALID_I && err_en_reg[`EN_GATT]; // R15
    sts_set[`ST_MEF] = MBIT_ERR_I;
    sts_set[`ST_SEF] = SBIT_ERR_I;
    sts_mask = 16'h0000;
    sts_mask[`ST_RTHR] = err_en_reg[`EN_THR]; // R11
    sts_mask[`ST_WTHR] = err_en_reg[`EN_THR]; // R11
    sts_mask[`ST_APER] = err_en_reg[`EN_APER]; // R13
    sts_mask[`ST_AGPRD] = err_en_reg[`EN_AGPRD]; // R14
    sts_mask[`ST_GATT] = err_en_reg[`EN_GATT]; // R15
    sts_mask[`ST_MEF] = err_en_reg[`EN_MBIT]; // R17
    sts_mask[`ST_SEF] = err_en_reg[`EN_SBIT]; // R18
  end
  assign sts_clr = (wr_go && awaddr_reg == `OFS_ERR_STATUS) ?
    ({wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
      wstrb_reg[0] ? wdata_reg[7:0] : 8'h00} & `STS_W1C_MASK) : 16'h0000;
  assign sts_rise = sts_set & ~err_sts_reg & `STS_W1C_MASK; // R21
  always @*
  begin
    // set wins over a same-cycle clear
    err_sts_next = (err_sts_reg & ~sts_clr) | (sts_set & `STS_W1C_MASK);
    // row fields lock while their flag stays set
    if (sts_rise[`ST_MEF])
      err_sts_next[7:5] = ERR_ROW_I;
    if (sts_rise[`ST_SEF])
      err_sts_next[3:1] = ERR_ROW_I;
  end
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      err_sts_reg <= 16'h0000;
    else
      err_sts_reg <= err_sts_next; // R20
  end
  assign serr_evt = serr_en_reg && ((|(sts_rise & sts_mask)) ||
    (TARGET_ABORT_I && err_en_reg[`EN_TABORT])); // R16 R19 R21
  assign serr_hold = serr_en_reg && (|(err_sts_reg & sts_mask)); // R19
  serr_signal_gen #(
    .PULSE_CYCLES(PCI_CYCLES)
  ) u_serr (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .event_i(serr_evt),
    .level_mode_i(err_en_reg[`EN_LEVEL]), // R12
    .hold_i(serr_hold),
    .serr_o(SERR_O)
  );
endmodule

// ### throttle_consts.vh
`ifndef THROTTLE_CONSTS_VH
`define THROTTLE_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_ERR_ENABLE 8'h90
`define OFS_ERR_STATUS 8'h94
`define OFS_SERR_CTRL 8'h98
`define OFS_THR_STATE 8'h9c
`define OFS_WT_LO 8'he0
`define OFS_WT_HI 8'he4
`define OFS_RT_LO 8'he8
`define OFS_RT_HI 8'hec
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define ERR_ENABLE_RST 8'h80
`define RT_RST 64'h0000000000000000
`define RT_WMASK 64'h00003ffffffffff8
`define STS_W1C_MASK 16'h1f11
// ----------------------------------------
// read throttle fields
// ----------------------------------------
`define GW_HI 45
`define GW_LO 38
`define GT_HI 37
`define GT_LO 26
`define RTT_HI 25
`define RTT_LO 20
`define MW_HI 19
`define MW_LO 13
`define QM_HI 12
`define QM_LO 3
`define GT_SHIFT 15
`define LOCK_BIT 31
// ----------------------------------------
// error enable bits
// ----------------------------------------
`define EN_SBIT 0
`define EN_MBIT 1
`define EN_LEVEL 2
`define EN_THR 3
`define EN_TABORT 4
`define EN_GATT 5
`define EN_AGPRD 6
`define EN_APER 7
// ----------------------------------------
// error status bits
// ----------------------------------------
`define ST_SEF 0
`define ST_MEF 4
`define ST_GATT 8
`define ST_AGPRD 9
`define ST_APER 10
`define ST_WTHR 11
`define ST_RTHR 12
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define PCI_CLK_NS 30
`define PCI_CYCLES ((`PCI_CLK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### serr_signal_gen.v
`timescale 1ns/1ps
`include "throttle_consts.vh"
module serr_signal_gen #(
  parameter PULSE_CYCLES = `PCI_CYCLES
)(
  input wire clk_i,
  input wire nrst_i,
  input wire event_i,
  input wire level_mode_i,
  input wire hold_i,
  output wire serr_o
);
  // ----------------------------------------
  // pulse timer and level latch
  // ----------------------------------------
  reg [7:0] pulse_cnt_reg;
  reg level_reg;
  reg out_reg;
  wire [7:0] pulse_len;
  assign pulse_len = PULSE_CYCLES[7:0];
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pulse_cnt_reg <= 8'h00;
      level_reg <= 1'b0;
      out_reg <= 1'b0;
    end
    else
    begin
      if (event_i && !level_mode_i)
        pulse_cnt_reg <= pulse_len; // R12
      else if (pulse_cnt_reg != 8'h00)
        pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      // level held while an enabled flag stays set
      if (event_i && level_mode_i)
        level_reg <= 1'b1; // R12
      else if (!hold_i || !level_mode_i)
        level_reg <= 1'b0;
      out_reg <= (event_i && !level_mode_i) ||
        (pulse_cnt_reg > 8'h01) ||
        (level_mode_i && (event_i || (level_reg && hold_i)));
    end
  end
  assign serr_o = out_reg;
endmodule

// ### dram_read_throttle_assertions.sv
`timescale 1ns/1ps
module drt_checker (
  input wire CLK_I,
  input wire NRST_I,
  input wire S_AXI_AWVALID_I,
  input wire S_AXI_AWREADY_O,
  input wire S_AXI_WVALID_I,
  input wire S_AXI_WREADY_O,
  input wire S_AXI_BVALID_O,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire [31:0] S_AXI_RDATA_O,
  input wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire QW_READ_I,
  input wire BLOCK_HOST_PCI_RD_O,
  input wire BLOCK_AGP_O,
  input wire THROTTLE_ACTIVE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ----------------------------------------
  // register bus handshakes
  // ----------------------------------------
  bvalid_timing_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
    && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
    else $error("write response not on time");
  rvalid_timing_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read response not on time");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped before taken");
  wready_low_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O
    && !S_AXI_WREADY_O) else $error("write taken while response pends");
  arready_rule_a: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O)
    else $error("read ready wrong");
  // ----------------------------------------
  // throttling outputs
  // ----------------------------------------
  block_pair_a: assert property (
    BLOCK_AGP_O == BLOCK_HOST_PCI_RD_O) else $error("block outputs differ");
  throttle_cause_a: assert property ($rose(THROTTLE_ACTIVE_O) |->
    $past(QW_READ_I) || $past(QW_READ_I, 2) || $past(QW_READ_I, 3))
    else $error("throttling without reads");
  block_cause_a: assert property ($rose(BLOCK_HOST_PCI_RD_O) |->
    THROTTLE_ACTIVE_O || $past(THROTTLE_ACTIVE_O))
    else $error("blocking outside throttling");
endmodule
bind dram_read_throttle drt_checker chk_u (.*);

// ### read_source.sv
`timescale 1ns/1ps
module read_source (
  input wire clk_i,
  input wire nrst_i,
  input wire want_i,
  input wire block_i,
  output reg qw_o
);
  // one quadword per cycle while wanted and not blocked
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      qw_o <= 1'b0;
    else
      qw_o <= want_i && !block_i;
  end
endmodule

// ### dram_read_throttle_tb.sv
`timescale 1ns/1ps
module dram_read_throttle_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  reg rready = 1'b0, want = 1'b0, sflag = 1'b0, pblk = 1'b0, first = 1'b1;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, lfsr = 32'h32b3, rd_val, lo, hi, m;
  reg [6:0] ev = 7'h00;
  reg [2:0] row = 3'h0;
  reg [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, qw, blk, thr, serr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer fail_count = 0, compares = 0, cyc = 0, i, k, n;
  integer bcnt = 0, nblk = 0, tl = 0;
  always #5 clk = ~clk;
  dram_read_throttle #(.MS_CYCLES(20)) dut_u (
    .CLK_I(clk), .NRST_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .QW_READ_I(qw), .WR_THROTTLE_EVT_I(ev[6]),
    .AGP_OUT_APERTURE_I(ev[5]), .AGP_INVALID_READ_I(ev[4]),
    .GATT_INVALID_I(ev[3]), .TARGET_ABORT_I(ev[2]), .MBIT_ERR_I(ev[1]),
    .SBIT_ERR_I(ev[0]), .ERR_ROW_I(row), .BLOCK_HOST_PCI_RD_O(blk),
    .BLOCK_AGP_O(), .THROTTLE_ACTIVE_O(thr), .SERR_O(serr));
  read_source src_u (.clk_i(clk), .nrst_i(rst_n), .want_i(want),
    .block_i(blk), .qw_o(qw));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // enable bit and status bit for event input j
  function integer en_of(input integer j);
    en_of = (j == 6) ? 3 : (j >= 2) ? j + 2 : j;
  endfunction
  function integer st_of(input integer j);
    st_of = (j == 0) ? 0 : (j == 1) ? 4 : (j == 2) ? 16 : j + 5;
  endfunction
  task report_and_stop;
  begin
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk_word(input [31:0] g, input [31:0] e);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task chk_count(input integer g, input integer e);
  begin
    chk_word(g, e);
  end
  endtask
  task axi_wr(input [7:0] a, input [31:0] v);
    reg pa, pw, ra, rw, b;
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      b = bvalid;
      resp = bresp;
      @(posedge clk);
      if (pa && ra)
        awvalid <= 1'b0;
      if (pw && rw)
        wvalid <= 1'b0;
      pa = pa && !ra;
      pw = pw && !rw;
    end
    bready <= 1'b0;
  end
  endtask
  task axi_rd(input [7:0] a);
    reg pa, q, r;
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      q = arready;
      r = rvalid;
      rd_val = rdata;
      resp = rresp;
      @(posedge clk);
      if (pa && q)
        arvalid <= 1'b0;
      pa = pa && !q;
    end
    rready <= 1'b0;
  end
  endtask
  task rchk(input [7:0] a, input [31:0] e);
  begin
    axi_rd(a);
    chk_word(rd_val, e);
  end
  endtask
  task pulse(input integer j);
  begin
    @(posedge clk);
    ev[j] <= 1'b1;
    row <= lfsr[2:0];
    lfsr = nxt(lfsr);
    @(posedge clk);
    ev <= 7'h00;
  end
  endtask
  task serr_len(input integer e);
  begin
    for (i = 0; i < 8 && !serr; i = i + 1)
      @(negedge clk);
    for (n = 0; n < 20 && serr; n = n + 1)
      @(negedge clk);
    chk_count(n, e);
  end
  endtask
  // throttle length, reads per monitor window, hang limit
  always @(negedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
    sflag = sflag | serr;
    if (thr)
      tl = tl + 1;
    else if (tl != 0)
    begin
      chk_count(tl, 160);
      tl = 0;
    end
    if (!thr)
      first = 1'b1;
    if (thr && blk && !pblk)
    begin
      if (!first)
        chk_count(bcnt, 5);
      first = 1'b0;
      nblk = nblk + 1;
    end
    if (pblk && !blk)
      bcnt = 0;
    else if (!blk && qw)
      bcnt = bcnt + 1;
    pblk = blk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h90, 32'h80);
    rchk(8'he8, 32'h0);
    rchk(8'he4, 32'h0);
    for (k = 0; k < 3; k = k + 1)
    begin
      lo = nxt(lfsr);
      hi = nxt(lo);
      lfsr = hi;
      axi_wr(8'he8, lo);
      axi_wr(8'hec, hi);
      rchk(8'he8, lo & 32'hfffffff8);
      rchk(8'hec, hi & 32'h00003fff);
    end
    axi_wr(8'h40, lo);
    chk_word({30'h0, resp}, 32'h2);
    rchk(8'h40, 32'h0);
    chk_word({30'h0, resp}, 32'h2);
    axi_wr(8'h98, 32'h1);
    for (k = 0; k < 7; k = k + 1)
    begin
      m = (32'h1 << st_of(k)) & 32'hffff;
      axi_wr(8'h90, 32'h1 << en_of(k));
      pulse(k);
      serr_len(3);
      axi_rd(8'h94);
      chk_word(rd_val & m, m);
      axi_wr(8'h94, 32'h1f11);
      axi_wr(8'h90, 32'h0);
      pulse(k);
      serr_len(0);
      axi_wr(8'h94, 32'h1f11);
    end
    axi_wr(8'h90, 32'h1);
    pulse(0);
    serr_len(3);
    pulse(0);
    serr_len(0);
    axi_wr(8'h94, 32'h1f11);
    axi_wr(8'h98, 32'h0);
    pulse(0);
    serr_len(0);
    axi_wr(8'h94, 32'h1f11);
    axi_wr(8'h98, 32'h1);
    axi_wr(8'h90, 32'h5);
    pulse(0);
    repeat (12) @(negedge clk);
    chk_word({31'h0, serr}, 32'h1);
    axi_wr(8'h94, 32'h1f11);
    repeat (4) @(negedge clk);
    chk_word({31'h0, serr}, 32'h0);
    // window 4 ms, threshold 0, 2 windows, monitor 32 clocks, max 5
    axi_wr(8'h90, 32'h8);
    axi_wr(8'he8, 32'h00204028);
    axi_wr(8'hec, 32'h40);
    want <= 1'b1;
    serr_len(3);
    axi_rd(8'h94);
    chk_word(rd_val & 32'h1000, 32'h1000);
    axi_wr(8'h94, 32'h1000);
    axi_rd(8'h94);
    chk_word(rd_val & 32'h1f11, 32'h0);
    axi_wr(8'h90, 32'h0);
    sflag = 1'b0;
    while (thr)
      @(negedge clk);
    while (!thr)
      @(negedge clk);
    axi_rd(8'h94);
    chk_word(rd_val & 32'h1000, 32'h1000);
    chk_word({31'h0, sflag}, 32'h0);
    @(posedge clk);
    want <= 1'b0;
    while (thr)
      @(negedge clk);
    chk_count(nblk > 1, 1);
    axi_wr(8'he4, 32'h80000000);
    rchk(8'he4, 32'h80000000);
    axi_wr(8'he8, 32'h0);
    chk_word({30'h0, resp}, 32'h0);
    rchk(8'he8, 32'h00204028);
    axi_wr(8'he4, 32'h0);
    rchk(8'he4, 32'h80000000);
    report_and_stop;
  end
endmodule
